//--- core/sdram_pkg.sv
// constants, command codes and carrier types for the sdram pin interface
// assumes one 200 MHz clock shared with the memory controller and the register bus
package sdram_pkg;
  localparam int ROW_W = 11; // row address width
  localparam int COL_W = 8; // column address width
  localparam int DATA_W = 32; // data pin width
  localparam int BYTES = 4; // one mask bit per byte lane
  localparam int WORDS_PER_BANK = 524288; // words in each bank
  localparam int BANKS = 2; // bank count
  localparam int MEM_ADDR_W = 20; // bank, row, column
  localparam int MEM_WORDS = BANKS * WORDS_PER_BANK; // whole array
  localparam int FULL_PAGE = 256; // full page burst length
  localparam int LEN_W = 9; // holds up to a full page
  // mode word layout
  localparam int MODE_BL_LSB = 0; // burst length code
  localparam int MODE_BT_BIT = 3; // 1 = interleaved order
  localparam int MODE_CL_LSB = 4; // read latency code
  localparam int MODE_WBL_BIT = 9; // 1 = single word writes
  localparam int AUTO_PRE_BIT = 10; // auto precharge / all banks
  localparam logic [ROW_W-1:0] MODE_RST = 11'h000; // mode word after reset
  localparam logic [ROW_W-1:0] EXT_RST = 11'h000; // extended word after reset
  // register bus map, byte addresses
  localparam int AVS_ADDR_W = 4; // register bus address width
  localparam logic [AVS_ADDR_W-1:0] REG_MODE = 4'h0; // mode word, rw
  localparam logic [AVS_ADDR_W-1:0] REG_EXT = 4'h4; // extended mode word, rw
  localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 4'h8; // live state, ro
  // timing
  localparam int CLK_PERIOD_NS = 5; // 200 MHz
  localparam int OUTPUT_FLOAT_DELAY_NS = 6; // pins float this long after the edge
  localparam int FLOAT_CYC = (OUTPUT_FLOAT_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                             OUTPUT_FLOAT_DELAY_NS / CLK_PERIOD_NS; // longest time, rounded down
  localparam int MAX_CL = 3; // deepest read latency

  // decoded pin command
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_MODE, CMD_STOP
  } cmd_t;

  // strobes sampled together at one edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } strobes_t;

  // status word as software sees it
  typedef struct packed {
    logic [BANKS-1:0] open_banks;
    logic burst_busy;
    logic powered_down;
  } status_t;
endpackage : sdram_pkg

//--- core/sdram_store.sv
// storage array of both banks, byte-writable, registered read port
// assumes at most one access per cycle, steered by the pin interface
`timescale 1ns/10ps
module sdram_store import sdram_pkg::*; (
  input wire logic i_clk, // system clock
  input wire logic i_rd_en, // load read register
  input wire logic i_wr_en, // write enabled lanes
  input wire logic [MEM_ADDR_W-1:0] i_addr, // bank, row, column
  input wire logic [DATA_W-1:0] i_wdata, // write data
  input wire logic [BYTES-1:0] i_be, // lanes to store
  output logic [DATA_W-1:0] o_rdata // registered read data
);
  logic [DATA_W-1:0] mem_q [MEM_WORDS]; // the cell array
  logic [DATA_W-1:0] rdata_q; // read register

  // one port; masked lanes keep their old content
  always_ff @(posedge i_clk) begin
    if (i_rd_en) begin
      rdata_q <= mem_q[i_addr];
    end
    for (int b = 0; b < BYTES; b++) begin
      if (i_wr_en && i_be[b]) begin
        mem_q[i_addr][b*8 +: 8] <= i_wdata[b*8 +: 8];
      end
    end
  end

  assign o_rdata = rdata_q;
endmodule : sdram_store

//--- core/sdram_pin_iface.sv
// pin-level command and data interface of a two-bank 32-bit sdram, with the array
// assumes the controller pins are synchronous to i_clk; registers on avalon-mm
//
// Overview of operation
// R01: all pins sampled on rising clock only
// R02: chip select high ignores commands
// R03: clock gate low freezes from next cycle
// R04: controller raises gate a cycle before commands
// R05: gate low while idle means power-down
// R06: row eleven bits, column low eight bits
// R07: bank bit picks bank for row, column
// R08: row strobe low latches row address
// R09: column strobe low latches column, starts access
// R10: write data taken in command cycle
// R11: read mask floats that byte lane
// R12: write mask keeps stored byte unchanged
// R13: two banks of 524288 32-bit words
// R14: new column command accepted every cycle
// R15: read latency one, two or three
// R16: burst 1, 2, 4, 8 or page
// R17: sequential or interleaved burst order
// R18: mode with burst reads, single writes
// R19: controller refreshes 4K rows per 64 ms
// R20: controller waits 200 us, precharges, refreshes, programs
// R21: bank bit selects mode or extended word
// R22: mode load idle only, then wait 2
// R23: address bit nine enables single writes
// R24: strobes decode standard sdram commands
// R25: read words leave one per cycle
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module sdram_pin_iface import sdram_pkg::*; (
  input wire logic i_clk, // system clock, 200 MHz
  input wire logic i_rst, // synchronous reset, high
  input wire logic i_clock_gate, // clock gate pin, high runs
  input wire logic i_chip_select_n, // chip select, low
  input wire logic i_row_strobe_n, // row strobe, low
  input wire logic i_column_strobe_n, // column strobe, low
  input wire logic i_write_strobe_n, // write strobe, low
  input wire logic i_array_select_bit, // bank select
  input wire logic [ROW_W-1:0] i_addr, // multiplexed address
  input wire logic [BYTES-1:0] i_byte_data_mask, // per-lane mask, high masks
  input wire logic [DATA_W-1:0] i_data_pins, // data pins, input side
  output logic [DATA_W-1:0] o_data_pins, // data pins, output side
  output logic [BYTES-1:0] o_data_pins_oe, // per-lane drive enable
  input wire logic [AVS_ADDR_W-1:0] i_avs_address, // register byte address
  input wire logic i_avs_read, // register read
  input wire logic i_avs_write, // register write
  input wire logic [DATA_W-1:0] i_avs_writedata, // register write data
  output logic [DATA_W-1:0] o_avs_readdata, // register read data
  output logic o_avs_waitrequest // high stalls the bus
);
  // state
  logic cke_q; // gate sampled at the last edge
  logic [ROW_W-1:0] mode_q; // mode word
  logic [ROW_W-1:0] ext_q; // extended mode word
  logic [BANKS-1:0] open_q; // bank holds an open row
  logic [ROW_W-1:0] row_q [BANKS]; // open row per bank
  logic burst_q; // burst words still to move
  logic burst_wr_q; // burst is a write
  logic burst_bank_q; // bank of the burst
  logic [COL_W-1:0] start_q; // starting column
  logic [COL_W-1:0] idx_q; // word index of next beat
  logic [LEN_W-1:0] len_q; // burst length
  logic bt_q; // interleaved order
  logic autopre_q; // close bank at burst end
  logic mem_v_q; // read register holds a word
  logic [DATA_W-1:0] pipe_q [MAX_CL-1]; // latency stages
  logic [MAX_CL-2:0] pipe_v_q; // stage valid bits
  logic [DATA_W-1:0] data_q; // output pin register
  logic [BYTES-1:0] oe_q; // output enable register
  logic pd_q; // power-down flag
  logic [DATA_W-1:0] rdata_q; // bus read register
  logic wait_q; // bus waitrequest

  // command decode, standard encoding
  function automatic cmd_t decode(input strobes_t s);
    cmd_t c;
    c = CMD_NOP;
    unique case ({s.ras_n, s.cas_n, s.we_n})
      3'b011: c = CMD_ACT;
      3'b101: c = CMD_READ;
      3'b100: c = CMD_WRITE;
      3'b010: c = CMD_PRE;
      3'b001: c = CMD_REF;
      3'b000: c = CMD_MODE;
      3'b110: c = CMD_STOP;
      3'b111: c = CMD_NOP;
    endcase
    return s.cs_n ? CMD_NOP : c; // [R02]
  endfunction : decode

  // burst length from code; reserved codes fall back to one word
  function automatic logic [LEN_W-1:0] burst_len(input logic [2:0] code, input logic bt);
    logic [LEN_W-1:0] n;
    n = 9'h001;
    unique case (code)
      3'h1: n = 9'h002;
      3'h2: n = 9'h004;
      3'h3: n = 9'h008;
      3'h7: n = bt ? 9'h001 : 9'h100; // page only in sequential order
      default: n = 9'h001;
    endcase
    return n;
  endfunction : burst_len

  wire run = cke_q; // [R03] gate low at edge t freezes edge t+1
  wire strobes_t pins = '{i_chip_select_n, i_row_strobe_n, i_column_strobe_n, i_write_strobe_n};
  wire cmd_t cmd = run ? decode(pins) : CMD_NOP; // [R24] [R01]
  wire ba = i_array_select_bit; // [R07]
  wire [COL_W-1:0] col_in = i_addr[COL_W-1:0]; // [R06] column on low pins
  wire bank_ok = open_q[ba]; // column commands need an open row
  wire acc_rd = (cmd == CMD_READ) && bank_ok; // [R09]
  wire acc_wr = (cmd == CMD_WRITE) && bank_ok; // [R09] [R10]
  wire acc_col = acc_rd || acc_wr; // [R14] any cycle, cuts a running burst
  wire [2:0] cl_code = mode_q[MODE_CL_LSB +: 3];
  wire [1:0] cl_eff = (cl_code == 3'h1) ? 2'd1 : (cl_code == 3'h2) ? 2'd2 : 2'd3; // [R15]
  wire mode_bt = mode_q[MODE_BT_BIT]; // [R17]
  wire [LEN_W-1:0] rd_len = burst_len(mode_q[MODE_BL_LSB +: 3], mode_bt); // [R16]
  wire [LEN_W-1:0] wr_len = mode_q[MODE_WBL_BIT] ? 9'h001 : rd_len; // [R18] [R23]
  wire [LEN_W-1:0] new_len = acc_wr ? wr_len : rd_len;
  // column of the next beat within the burst window
  wire [COL_W-1:0] len_mask = COL_W'(len_q - 9'h001);
  wire [COL_W-1:0] beat_off = bt_q ? (start_q ^ idx_q) : COL_W'(start_q + idx_q); // [R17]
  wire [COL_W-1:0] beat_col = (start_q & ~len_mask) | (beat_off & len_mask);
  wire beat = run && burst_q && !acc_col; // burst beat this cycle
  wire last_beat = beat && (idx_q == COL_W'(len_q - 9'h001)); // both sides column wide
  wire [MEM_ADDR_W-1:0] mem_addr = acc_col ? {ba, row_q[ba], col_in}
                                           : {burst_bank_q, row_q[burst_bank_q], beat_col}; // [R13]
  wire mem_rd = acc_rd || (beat && !burst_wr_q); // [R25]
  wire mem_wr = acc_wr || (beat && burst_wr_q); // [R10]
  wire [BYTES-1:0] mem_be = ~i_byte_data_mask; // [R12]
  wire [DATA_W-1:0] mem_rdata;
  wire idle = (open_q == '0) && !burst_q;
  wire mode_ok = (cmd == CMD_MODE) && (open_q == '0);
  // read data at the chosen latency
  wire [DATA_W-1:0] lat_data = (cl_eff == 2'd1) ? mem_rdata : (cl_eff == 2'd2) ? pipe_q[0] : pipe_q[1];
  wire lat_v = (cl_eff == 2'd1) ? mem_v_q : (cl_eff == 2'd2) ? pipe_v_q[0] : pipe_v_q[1];
  // register bus decode
  wire bus_req = i_avs_read || i_avs_write;
  wire bus_wr = i_avs_write && !wait_q; // write lands at the completing edge
  wire status_t status = '{open_q, burst_q, pd_q};
  wire [DATA_W-1:0] bus_rd = (i_avs_address == REG_MODE) ? {21'h00_0000, mode_q} :
                             (i_avs_address == REG_EXT) ? {21'h00_0000, ext_q} :
                             (i_avs_address == REG_STATUS) ? {28'h000_0000, status} : 32'h0000_0000;

  sdram_store u_store (
    .i_clk(i_clk),
    .i_rd_en(mem_rd),
    .i_wr_en(mem_wr),
    .i_addr(mem_addr),
    .i_wdata(i_data_pins),
    .i_be(mem_be),
    .o_rdata(mem_rdata)
  );

  // gate sampling and power-down flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cke_q <= 1'b1;
      pd_q <= 1'b0;
    end else begin
      cke_q <= i_clock_gate; // [R01] [R03]
      pd_q <= !i_clock_gate && idle; // [R05] buffers off, commands ignored
    end
  end

  // mode words; pin loads win over a bus write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_q <= MODE_RST;
      ext_q <= EXT_RST;
    end else if (mode_ok && !ba) begin
      mode_q <= i_addr; // [R21] [R23]
    end else if (mode_ok && ba) begin
      ext_q <= i_addr; // [R21]
    end else if (bus_wr && i_avs_address == REG_MODE) begin
      mode_q <= i_avs_writedata[ROW_W-1:0];
    end else if (bus_wr && i_avs_address == REG_EXT) begin
      ext_q <= i_avs_writedata[ROW_W-1:0];
    end
  end

  // bank open and close
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      open_q <= '0;
      row_q <= '{default: '0};
    end else if (cmd == CMD_ACT && !open_q[ba]) begin
      open_q[ba] <= 1'b1; // [R08] [R07]
      row_q[ba] <= i_addr; // [R06] row on all pins
    end else if (cmd == CMD_PRE) begin
      open_q <= i_addr[AUTO_PRE_BIT] ? '0 : (open_q & ~(2'b01 << ba)); // [R08]
    end else if (acc_col && new_len == 9'h001 && i_addr[AUTO_PRE_BIT]) begin
      open_q[ba] <= 1'b0; // single word with auto precharge
    end else if (last_beat && autopre_q) begin
      open_q[burst_bank_q] <= 1'b0;
    end
  end

  // burst sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      burst_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_bank_q <= 1'b0;
      start_q <= '0;
      idx_q <= '0;
      len_q <= 9'h001;
      bt_q <= 1'b0;
      autopre_q <= 1'b0;
    end else if (acc_col) begin
      burst_q <= (new_len != 9'h001); // [R16]
      burst_wr_q <= acc_wr;
      burst_bank_q <= ba;
      start_q <= col_in;
      idx_q <= 8'h01;
      len_q <= new_len;
      bt_q <= mode_bt;
      autopre_q <= i_addr[AUTO_PRE_BIT];
    end else if (cmd == CMD_STOP || (cmd == CMD_PRE && (i_addr[AUTO_PRE_BIT] || ba == burst_bank_q))) begin
      burst_q <= 1'b0; // stop, or a precharge of its bank or of all banks, cuts the burst
    end else if (beat) begin
      idx_q <= idx_q + 8'h01;
      burst_q <= !last_beat;
    end
  end

  // read latency pipe and pin drivers, all held while frozen
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mem_v_q <= 1'b0;
      pipe_q <= '{default: '0};
      pipe_v_q <= '0;
      data_q <= 32'h0000_0000;
      oe_q <= '0;
    end else if (run) begin
      mem_v_q <= mem_rd;
      pipe_q[0] <= mem_rdata;
      pipe_q[1] <= pipe_q[0];
      pipe_v_q <= {pipe_v_q[0], mem_v_q};
      data_q <= lat_data; // [R15] [R25]
      oe_q <= {BYTES{lat_v}} & ~i_byte_data_mask; // [R11]
    end
  end

  // register bus: one wait cycle, then the request completes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !(bus_req && wait_q);
      if (bus_req && wait_q) begin
        rdata_q <= i_avs_read ? bus_rd : 32'h0000_0000;
      end
    end
  end

  assign o_data_pins = data_q;
  assign o_data_pins_oe = oe_q;
  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_rd_cl2;
    acc_rd && cl_eff == 2'd2 ##1 run ##1 (run && i_byte_data_mask == 4'h0);
  endsequence
  sequence s_quad_read;
    acc_rd && rd_len == 9'h004 ##1 (run && cmd == CMD_NOP)[*3];
  endsequence

  AST_FREEZE: assert property (!run |=> $stable(o_data_pins) && $stable(o_data_pins_oe)) // [R03]
    else $error("pins changed while frozen");
  AST_CS_IGNORE: assert property (i_chip_select_n |=> $stable(open_q) && $stable(row_q[0])) // [R02]
    else $error("command taken with chip select high");
  AST_ROW_LATCH: assert property (cmd == CMD_ACT && !open_q[ba] |=> open_q[$past(ba)] // [R08]
    && row_q[$past(ba)] == $past(i_addr)) else $error("row not latched");
  AST_READ_LAT: assert property (s_rd_cl2 |=> o_data_pins_oe == 4'hF) // [R15]
    else $error("read data late or early");
  // float delay is one cycle at this clock, so the lane drops at the next output edge
  AST_MASK_FLOAT: assert property (run && i_byte_data_mask[0] |-> ##1 !o_data_pins_oe[0]) // [R11]
    else $error("masked lane still driven");
  AST_WRITE_TAKE: assert property (acc_wr |-> mem_wr && mem_addr[COL_W-1:0] == i_addr[COL_W-1:0] // [R10]
    && mem_be == ~i_byte_data_mask) else $error("write data not taken");
  AST_BURST_FOUR: assert property (s_quad_read |=> !burst_q && $past(burst_q)) // [R16]
    else $error("burst of four wrong length");
  AST_SINGLE_WRITE: assert property (acc_wr && mode_q[MODE_WBL_BIT] |=> !burst_q) // [R18]
    else $error("write burst in single write mode");
  AST_MODE_LOAD: assert property (mode_ok && !ba |=> mode_q == $past(i_addr)) // [R21]
    else $error("mode word not loaded");
  AST_POWER_DOWN: assert property (!i_clock_gate && idle |=> pd_q) // [R05]
    else $error("no power-down while idle");
endmodule : sdram_pin_iface

//--- tb/pin_ctrl_model.sv
// behavioural memory controller that drives the pin side of the sdram interface
// assumes the bench calls its tasks from one process, each task starting at a rising edge
`timescale 1ns/10ps
module pin_ctrl_model import sdram_pkg::*; #(
  parameter int INIT_CYC = 40000 // 200 us of nop at 5 ns per cycle
) (
  input wire logic i_clk, // system clock
  output logic o_gate, // clock gate pin
  output strobes_t o_stb, // cs, ras, cas, we, low active
  output logic o_ba, // bank select
  output logic [ROW_W-1:0] o_addr, // multiplexed address
  output logic [BYTES-1:0] o_mask, // byte masks
  output logic [DATA_W-1:0] o_data // data pins as driven by the controller
);
  // power-up state: gate high, masks high, nop on the strobes
  initial begin
    o_gate = 1'b1;
    o_stb = 4'hF;
    o_ba = 1'b0;
    o_addr = 11'h000;
    o_mask = 4'hF;
    o_data = 32'h0000_0000;
  end
  // one command, sampled at the next edge; all strobes in one carrier
  task automatic cmd(input strobes_t s, input logic b, input logic [ROW_W-1:0] a, input logic [BYTES-1:0] m,
                     input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_stb <= s;
    o_ba <= b;
    o_addr <= a;
    o_mask <= m;
    o_data <= d;
  endtask : cmd
  // further write beat with nop on the strobes
  task automatic beat(input logic [BYTES-1:0] m, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_stb <= 4'hF;
    o_mask <= m;
    o_data <= d;
  endtask : beat
  // nop; the mask stays so that a read keeps its mask through the burst
  task automatic idle();
    @(posedge i_clk);
    o_stb <= 4'hF;
    o_data <= ~o_data; // released pins must not keep showing the last word
  endtask : idle
  // mode or extended word load, then the quiet gap before new commands
  task automatic load(input logic b, input logic [ROW_W-1:0] w);
    cmd(4'h0, b, w, 4'h0, 32'h0000_0000);
    repeat (3) idle();
  endtask : load
  // gate change; a rise is followed by a full cycle before any command
  task automatic gate(input logic v);
    @(posedge i_clk);
    o_gate <= v;
    if (v) begin
      @(posedge i_clk);
    end
  endtask : gate
  // power-up: long nop, close both banks, two refreshes; mode comes from the bench
  task automatic init();
    repeat (INIT_CYC) @(posedge i_clk);
    o_mask <= 4'h0;
    cmd(4'h2, 1'b0, 11'h400, 4'h0, 32'h0000_0000);
    idle();
    repeat (2) begin
      cmd(4'h1, 1'b0, 11'h000, 4'h0, 32'h0000_0000);
      idle();
    end
  endtask : init
endmodule : pin_ctrl_model

//--- tb/test_sdram_pin_iface.sv
// self-checking bench: pin commands, burst order, latency, masks, register bus
// assumes the package, the design and the controller model are compiled first
`timescale 1ns/10ps
module test_sdram_pin_iface import sdram_pkg::*;;
  logic i_clk; // system clock
  logic i_rst; // synchronous reset
  logic gate; // clock gate from the controller
  strobes_t stb; // command strobes
  logic ba; // bank select
  logic [ROW_W-1:0] addr; // multiplexed address
  logic [BYTES-1:0] mask; // byte masks
  logic [DATA_W-1:0] wdata; // controller data onto the pins
  logic [DATA_W-1:0] rdata; // device data from the pins
  logic [BYTES-1:0] oe; // device lane drive
  logic [AVS_ADDR_W-1:0] avs_address; // bus address
  logic avs_read; // bus read
  logic avs_write; // bus write
  logic [DATA_W-1:0] avs_writedata; // bus write data
  logic [DATA_W-1:0] avs_readdata; // bus read data
  logic avs_waitrequest; // bus stall
  logic [DATA_W-1:0] em [0:511]; // expected array for row 5, {bank, column}
  logic [DATA_W-1:0] r; // bus read result
  int fails; // mismatches
  int checks_done; // comparisons

  pin_ctrl_model ctrl (.i_clk(i_clk), .o_gate(gate), .o_stb(stb), .o_ba(ba), .o_addr(addr), .o_mask(mask),
    .o_data(wdata));
  sdram_pin_iface dut (.i_clk(i_clk), .i_rst(i_rst), .i_clock_gate(gate), .i_chip_select_n(stb.cs_n),
    .i_row_strobe_n(stb.ras_n), .i_column_strobe_n(stb.cas_n), .i_write_strobe_n(stb.we_n),
    .i_array_select_bit(ba), .i_addr(addr), .i_byte_data_mask(mask), .i_data_pins(wdata),
    .o_data_pins(rdata), .o_data_pins_oe(oe), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [AVS_ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q);
    @(posedge i_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge i_clk);
    while (avs_waitrequest !== 1'b0) @(posedge i_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  // column of beat k inside a burst of n
  function automatic logic [7:0] col_of(input logic [7:0] c, input int k, input int n, input logic il);
    logic [7:0] m;
    m = 8'(n - 1);
    return (c & ~m) | ((il ? (c ^ 8'(k)) : (c + 8'(k))) & m);
  endfunction : col_of
  // burst write; beat mb has lane 1 masked; one = only the first beat is stored
  task automatic wr(input logic b, input logic [7:0] c, input int n, input logic il, input logic one, input int mb,
                    input logic [DATA_W-1:0] base);
    logic [DATA_W-1:0] d;
    logic [8:0] i;
    for (int k = 0; k < n; k++) begin
      d = base + 32'(k);
      i = {b, col_of(c, k, n, il)};
      if (k == 0) ctrl.cmd(4'h4, b, {3'h0, c}, (mb == 0) ? 4'h2 : 4'h0, d);
      else ctrl.beat((mb == k) ? 4'h2 : 4'h0, d);
      if (!one || k == 0) em[i] = (mb == k) ? {d[31:16], em[i][15:8], d[7:0]} : d;
    end
    ctrl.idle();
  endtask : wr
  // burst read at latency cl, every word and the lane drive checked
  task automatic rd(input logic b, input logic [7:0] c, input int n, input logic il, input int cl);
    ctrl.cmd(4'h5, b, {3'h0, c}, 4'h0, 32'h0000_0000);
    ctrl.idle();
    repeat (cl) @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      #1;
      chk("read word", em[{b, col_of(c, k, n, il)}], rdata);
      chk("lane drive", 32'h0000_000F, {28'h0, oe});
      @(posedge i_clk);
    end
    #1;
    chk("drive after burst", 32'h0000_0000, {28'h0, oe});
  endtask : rd
  task automatic t_regs();
    #1;
    chk("reset drive", 32'h0000_0000, {28'h0, oe});
    bus(1'b1, REG_EXT, 32'h0000_0055, r);
    bus(1'b0, REG_EXT, 32'h0000_0000, r);
    chk("ext word", 32'h0000_0055, r);
    bus(1'b1, 4'hC, 32'h0000_0077, r);
    bus(1'b0, 4'hC, 32'h0000_0000, r);
    chk("unmapped", 32'h0000_0000, r);
  endtask : t_regs
  task automatic t_mode();
    ctrl.load(1'b0, 11'h022);
    bus(1'b0, REG_MODE, 32'h0000_0000, r);
    chk("mode word", 32'h0000_0022, r);
    ctrl.load(1'b1, 11'h011);
    bus(1'b0, REG_EXT, 32'h0000_0000, r);
    chk("ext word", 32'h0000_0011, r);
  endtask : t_mode
  task automatic t_data();
    ctrl.cmd(4'h3, 1'b0, 11'h005, 4'h0, 32'h0000_0000);
    wr(1'b0, 8'h00, 4, 1'b0, 1'b0, -1, 32'hA000_0000);
    wr(1'b0, 8'h01, 4, 1'b0, 1'b0, 2, 32'hB000_0000);
    rd(1'b0, 8'h00, 4, 1'b0, 2);
    ctrl.cmd(4'h2, 1'b0, 11'h400, 4'h0, 32'h0000_0000);
    ctrl.load(1'b0, 11'h02A);
    ctrl.cmd(4'h3, 1'b0, 11'h005, 4'h0, 32'h0000_0000);
    rd(1'b0, 8'h01, 4, 1'b1, 2);
    ctrl.cmd(4'h3, 1'b1, 11'h005, 4'h0, 32'h0000_0000);
    wr(1'b1, 8'h00, 4, 1'b1, 1'b0, -1, 32'hC000_0000);
    ctrl.cmd(4'hC, 1'b1, 11'h000, 4'h0, 32'hDEAD_BEEF);
    ctrl.idle();
    ctrl.gate(1'b0);
    ctrl.cmd(4'h4, 1'b1, 11'h000, 4'h0, 32'h5555_5555);
    ctrl.idle();
    ctrl.gate(1'b1);
    rd(1'b1, 8'h00, 4, 1'b1, 2);
    ctrl.cmd(4'h5, 1'b0, 11'h000, 4'h0, 32'h0000_0000);
    ctrl.cmd(4'h5, 1'b1, 11'h000, 4'h0, 32'h0000_0000);
    ctrl.idle();
    @(posedge i_clk);
    #1;
    chk("cut burst", em[0], rdata);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      #1;
      chk("next burst", em[{1'b1, col_of(8'h00, k, 4, 1'b1)}], rdata);
    end
  endtask : t_data
  task automatic t_latency();
    for (int cl = 1; cl <= 3; cl++) begin
      ctrl.cmd(4'h2, 1'b0, 11'h400, 4'h0, 32'h0000_0000);
      ctrl.load(1'b0, 11'(cl * 16));
      ctrl.cmd(4'h3, 1'b0, 11'h005, 4'h0, 32'h0000_0000);
      ctrl.cmd(4'h5, 1'b0, 11'h002, 4'h1, 32'h0000_0000);
      ctrl.idle();
      repeat (cl - 1) @(posedge i_clk);
      #1;
      chk("early drive", 32'h0000_0000, {28'h0, oe});
      @(posedge i_clk);
      #1;
      chk("masked drive", 32'h0000_000E, {28'h0, oe});
      chk("masked word", em[2] & 32'hFFFF_FF00, rdata & 32'hFFFF_FF00);
    end
    ctrl.cmd(4'h2, 1'b0, 11'h400, 4'h0, 32'h0000_0000);
    ctrl.load(1'b0, 11'h222);
    ctrl.cmd(4'h3, 1'b0, 11'h005, 4'h0, 32'h0000_0000);
    wr(1'b0, 8'h00, 4, 1'b0, 1'b1, -1, 32'hE000_0000);
    rd(1'b0, 8'h00, 4, 1'b0, 2);
  endtask : t_latency
  // burst stop cuts a read of eight; gate low with both banks closed powers down
  task automatic t_stop_pd();
    ctrl.cmd(4'h2, 1'b0, 11'h400, 4'h0, 32'h0000_0000);
    ctrl.load(1'b0, 11'h023);
    ctrl.cmd(4'h3, 1'b0, 11'h005, 4'h0, 32'h0000_0000);
    ctrl.cmd(4'h5, 1'b0, 11'h000, 4'h0, 32'h0000_0000);
    ctrl.cmd(4'h6, 1'b0, 11'h000, 4'h0, 32'h0000_0000);
    ctrl.idle();
    repeat (3) @(posedge i_clk);
    #1;
    chk("drive after stop", 32'h0000_0000, {28'h0, oe});
    ctrl.cmd(4'h2, 1'b0, 11'h400, 4'h0, 32'h0000_0000);
    ctrl.idle();
    ctrl.gate(1'b0);
    bus(1'b0, REG_STATUS, 32'h0000_0000, r);
    chk("power-down status", 32'h0000_0001, r);
    ctrl.gate(1'b1);
    bus(1'b0, REG_STATUS, 32'h0000_0000, r);
    chk("awake status", 32'h0000_0000, r);
  endtask : t_stop_pd

  // watchdog: init takes about 200 us, the rest a few microseconds
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  // main sequence
  initial begin
    fails = 0;
    checks_done = 0;
    i_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    ctrl.init();
    t_mode();
    t_data();
    t_latency();
    t_stop_pd();
    stop_test();
  end
endmodule : test_sdram_pin_iface
